/* File: adc_cfg_pkg.sv */
package adc_cfg_pkg;

    // Register offsets on the control port
    localparam logic [7:0] CH1_PHASE_DELAY_CONFIG_OFS = 8'h54;
    localparam logic [7:0] CH2_INPUT_CONFIG_OFS       = 8'h55;
    localparam logic [7:0] CH2_VOLUME_CONFIG_OFS      = 8'h57;

    // Values after reset
    localparam logic [7:0] CH1_PHASE_DELAY_CONFIG_RST = 8'h00;
    localparam logic [7:0] CH2_INPUT_CONFIG_RST       = 8'h00;
    localparam logic [7:0] CH2_VOLUME_CONFIG_RST      = 8'hA1;

    // Field positions
    localparam int CH1_PHASE_DELAY_LSB        = 2;
    localparam int CH1_PHASE_PATH_LSB         = 0;
    localparam int CH2_INPUT_SOURCE_LSB       = 6;
    localparam int CH2_INPUT_IMPEDANCE_LSB    = 4;
    localparam int CH2_CM_TOLERANCE_LSB       = 2;
    localparam int CH2_FULL_SCALE_SELECT_BIT  = 1;
    localparam int CH2_BANDWIDTH_SELECT_BIT   = 0;

    // Delay line geometry and volume codes
    localparam int         PHASE_HIST_LEN     = 63;
    localparam logic [7:0] VOLUME_MUTE_CODE   = 8'h00;
    localparam logic [7:0] VOLUME_0DB_CODE    = 8'hA1;
    localparam logic [7:0] VOLUME_MAX_CODE    = 8'hFF;

    typedef enum logic [1:0] {
        PATH_BOTH     = 2'b00,
        PATH_ANALOG   = 2'b01,
        PATH_DIGITAL  = 2'b10,
        PATH_RESERVED = 2'b11
    } phase_path_t;

    typedef enum logic [1:0] {
        SRC_DIFFERENTIAL  = 2'b00,
        SRC_SINGLE_ENDED  = 2'b01,
        SRC_POSITIVE_MUX  = 2'b10,
        SRC_NEGATIVE_MUX  = 2'b11
    } input_source_t;

    typedef enum logic [1:0] {
        IMP_5K       = 2'b00,
        IMP_10K      = 2'b01,
        IMP_40K      = 2'b10,
        IMP_RESERVED = 2'b11
    } input_impedance_t;

    typedef enum logic [1:0] {
        TOL_AC_LOW       = 2'b00,
        TOL_AC_DC_MID    = 2'b01,
        TOL_RAIL_TO_RAIL = 2'b10,
        TOL_RESERVED     = 2'b11
    } cm_tolerance_t;

    // Field layouts, most significant field first
    typedef struct packed {
        logic [5:0]  ch1_phase_delay;
        phase_path_t ch1_phase_path;
    } ch1_phase_cfg_t;

    typedef struct packed {
        input_source_t    ch2_input_source;
        input_impedance_t ch2_input_impedance;
        cm_tolerance_t    ch2_common_mode_tolerance;
        logic             ch2_full_scale_select;
        logic             ch2_bandwidth_select;
    } ch2_input_cfg_t;

    // Host register access from the control port engine
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       ana_bit;
        logic       dig_bit;
    } mod_pair_t;

endpackage

/* File: adc_channel_config_regs.sv */
`timescale 1ns/1ps

// Behaviour
// - Channel 1 delay equals field value, modulator cycles
// - Path select applies delay to analog/digital
// - Channel 2 source field selects input mux
// - Channel 2 impedance field drives impedance select
// - Channel 2 tolerance field drives coupling select
// - Full scale 4 Vrms only with rail-to-rail
// - Wide bandwidth only with 40 kilohm impedance
// - Volume code drives gain; zero mutes
// - Registers reset to 00, 00, A1
module adc_channel_config_regs
    import adc_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic           i_ref_clk,
    input  wire logic           i_rst_n,
    // Register access from control port
    input  wire reg_req_t       i_reg_req,
    output logic                o_reg_hit,
    output logic [7:0]          o_reg_rdata,
    output logic                o_reg_rd_valid,
    // Modulator streams of channel 1
    input  wire logic           i_mod_clk_en,
    input  wire mod_pair_t      i_ch1_mod,
    output mod_pair_t           o_ch1_mod,
    // Channel configuration outputs
    output ch1_phase_cfg_t      o_ch1_phase_cfg,
    output ch2_input_cfg_t      o_ch2_input_cfg,
    output logic [7:0]          o_ch2_digital_volume,
    output logic                o_ch2_mute,
    output logic                o_ch2_config_conflict
);

    typedef struct packed {
        ch1_phase_cfg_t              ch1;
        ch2_input_cfg_t              ch2_in;
        logic [7:0]                  ch2_vol;
        logic [PHASE_HIST_LEN-1:0]   ana_hist;
        logic [PHASE_HIST_LEN-1:0]   dig_hist;
        mod_pair_t                   mod_out;
        logic [7:0]                  rdata;
        logic                        rd_valid;
        logic                        mute;
        logic                        conflict;
    } state_t;

    localparam state_t STATE_RST = '{
        ch1:      ch1_phase_cfg_t'(CH1_PHASE_DELAY_CONFIG_RST),
        ch2_in:   ch2_input_cfg_t'(CH2_INPUT_CONFIG_RST),
        ch2_vol:  CH2_VOLUME_CONFIG_RST,
        ana_hist: '0,
        dig_hist: '0,
        mod_out:  '0,
        rdata:    8'h00,
        rd_valid: 1'b0,
        mute:     1'b0,
        conflict: 1'b0
    };

    state_t state_reg;
    state_t state_next;

    logic   hit_ch1;
    logic   hit_ch2_in;
    logic   hit_ch2_vol;
    logic   ana_delayed;
    logic   dig_delayed;
    logic   ana_sel;
    logic   dig_sel;
    logic [5:0] tap_idx;

    // Address decode
    assign hit_ch1     = (i_reg_req.addr == CH1_PHASE_DELAY_CONFIG_OFS);
    assign hit_ch2_in  = (i_reg_req.addr == CH2_INPUT_CONFIG_OFS);
    assign hit_ch2_vol = (i_reg_req.addr == CH2_VOLUME_CONFIG_OFS);
    assign o_reg_hit   = (i_reg_req.wr_en | i_reg_req.rd_en)
                         & (hit_ch1 | hit_ch2_in | hit_ch2_vol);

    // Tap of the delay line for the programmed delay
    assign tap_idx = state_reg.ch1.ch1_phase_delay - 6'h01;

    always_comb begin
        if (state_reg.ch1.ch1_phase_delay == 6'h00) begin
            ana_delayed = i_ch1_mod.ana_bit;
            dig_delayed = i_ch1_mod.dig_bit;
        end else begin
            ana_delayed = state_reg.ana_hist[tap_idx];
            dig_delayed = state_reg.dig_hist[tap_idx];
        end
    end

    // Path selection of the delayed streams
    always_comb begin
        ana_sel = i_ch1_mod.ana_bit;
        dig_sel = i_ch1_mod.dig_bit;
        case (state_reg.ch1.ch1_phase_path)
            PATH_BOTH: begin
                ana_sel = ana_delayed;
                dig_sel = dig_delayed;
            end
            PATH_ANALOG: begin
                ana_sel = ana_delayed;
            end
            PATH_DIGITAL: begin
                dig_sel = dig_delayed;
            end
            default: begin
                ana_sel = i_ch1_mod.ana_bit;
                dig_sel = i_ch1_mod.dig_bit;
            end
        endcase
    end

    always_comb begin
        state_next          = state_reg;
        state_next.rd_valid = 1'b0;

        // Register writes; reserved codes are kept as written
        if (i_reg_req.wr_en) begin
            if (hit_ch1) begin
                state_next.ch1 = ch1_phase_cfg_t'(i_reg_req.wdata);
            end
            if (hit_ch2_in) begin
                state_next.ch2_in = ch2_input_cfg_t'(i_reg_req.wdata);
            end
            if (hit_ch2_vol) begin
                state_next.ch2_vol = i_reg_req.wdata;
            end
        end

        // Register reads; unmapped addresses return zero
        if (i_reg_req.rd_en) begin
            state_next.rd_valid = 1'b1;
            if (hit_ch1) begin
                state_next.rdata = state_reg.ch1;
            end else if (hit_ch2_in) begin
                state_next.rdata = state_reg.ch2_in;
            end else if (hit_ch2_vol) begin
                state_next.rdata = state_reg.ch2_vol;
            end else begin
                state_next.rdata = 8'h00;
            end
        end

        // Delay line advances once per modulator cycle
        if (i_mod_clk_en) begin
            state_next.ana_hist = {state_reg.ana_hist[PHASE_HIST_LEN-2:0],
                                   i_ch1_mod.ana_bit};
            state_next.dig_hist = {state_reg.dig_hist[PHASE_HIST_LEN-2:0],
                                   i_ch1_mod.dig_bit};
            state_next.mod_out.ana_bit = ana_sel;
            state_next.mod_out.dig_bit = dig_sel;
        end

        // Derived flags from the stored settings
        state_next.mute = (state_next.ch2_vol == VOLUME_MUTE_CODE);
        state_next.conflict =
            (state_next.ch2_in.ch2_full_scale_select
             & ((state_next.ch2_in.ch2_common_mode_tolerance != TOL_RAIL_TO_RAIL)
                | state_next.ch2_in.ch2_bandwidth_select))
            | (state_next.ch2_in.ch2_bandwidth_select
               & (state_next.ch2_in.ch2_input_impedance != IMP_40K));
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs from the state register
    assign o_reg_rdata           = state_reg.rdata;
    assign o_reg_rd_valid        = state_reg.rd_valid;
    assign o_ch1_mod             = state_reg.mod_out;
    assign o_ch1_phase_cfg       = state_reg.ch1;
    assign o_ch2_input_cfg       = state_reg.ch2_in;
    assign o_ch2_digital_volume  = state_reg.ch2_vol;
    assign o_ch2_mute            = state_reg.mute;
    assign o_ch2_config_conflict = state_reg.conflict;


endmodule // adc_channel_config_regs

/* File: adc_channel_config_regs_checker.sv */
`timescale 1ns/1ps
module adc_channel_config_regs_checker
    import adc_cfg_pkg::*;
(
    input wire logic           i_ref_clk, i_rst_n, i_mod_clk_en, o_reg_hit, o_reg_rd_valid,
    input wire logic           o_ch2_mute, o_ch2_config_conflict,
    input wire reg_req_t       i_reg_req,
    input wire mod_pair_t      i_ch1_mod, o_ch1_mod,
    input wire ch1_phase_cfg_t o_ch1_phase_cfg,
    input wire ch2_input_cfg_t o_ch2_input_cfg,
    input wire logic [7:0]     o_reg_rdata, o_ch2_digital_volume
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr(a);
        i_reg_req.wr_en && i_reg_req.addr == a;
    endsequence
    a_phase_write: assert property (s_wr(CH1_PHASE_DELAY_CONFIG_OFS)
        |=> o_ch1_phase_cfg == $past(i_reg_req.wdata)) else $error("phase cfg not written");
    a_src_write: assert property (s_wr(CH2_INPUT_CONFIG_OFS)
        |=> o_ch2_input_cfg == $past(i_reg_req.wdata)) else $error("input cfg not written");
    a_vol_write: assert property (s_wr(CH2_VOLUME_CONFIG_OFS)
        |=> o_ch2_digital_volume == $past(i_reg_req.wdata)) else $error("volume not written");
    a_mute_level: assert property (o_ch2_mute == (o_ch2_digital_volume == VOLUME_MUTE_CODE))
        else $error("mute wrong");
    a_cfg_hold: assert property (!i_reg_req.wr_en |=> $stable(o_ch2_input_cfg))
        else $error("input cfg changed");
    a_conflict_flag: assert property (o_ch2_config_conflict ==
        ((o_ch2_input_cfg.ch2_full_scale_select && (o_ch2_input_cfg.ch2_common_mode_tolerance
        != TOL_RAIL_TO_RAIL || o_ch2_input_cfg.ch2_bandwidth_select)) || (o_ch2_input_cfg
        .ch2_bandwidth_select && o_ch2_input_cfg.ch2_input_impedance != IMP_40K)))
        else $error("conflict flag wrong");
    a_vol_read: assert property (i_reg_req.rd_en && i_reg_req.addr == CH2_VOLUME_CONFIG_OFS
        |=> o_reg_rd_valid && o_reg_rdata == $past(o_ch2_digital_volume)) else $error("bad read");
    a_delay_zero: assert property (i_mod_clk_en && o_ch1_phase_cfg == 8'h00
        |=> o_ch1_mod == $past(i_ch1_mod)) else $error("zero delay wrong");
    a_ana_only: assert property (i_mod_clk_en && o_ch1_phase_cfg.ch1_phase_path == PATH_ANALOG
        |=> o_ch1_mod.dig_bit == $past(i_ch1_mod.dig_bit)) else $error("digital delayed");
    a_mod_hold: assert property (!i_mod_clk_en |=> $stable(o_ch1_mod))
        else $error("stream moved");
    a_hit_decode: assert property (o_reg_hit == ((i_reg_req.wr_en || i_reg_req.rd_en)
        && (i_reg_req.addr == CH1_PHASE_DELAY_CONFIG_OFS || i_reg_req.addr == CH2_INPUT_CONFIG_OFS
        || i_reg_req.addr == CH2_VOLUME_CONFIG_OFS))) else $error("hit decode wrong");
endmodule // adc_channel_config_regs_checker
bind adc_channel_config_regs adc_channel_config_regs_checker chk (.i_ref_clk, .i_rst_n,
    .i_mod_clk_en, .o_reg_hit, .o_reg_rd_valid, .o_ch2_mute, .o_ch2_config_conflict, .i_reg_req,
    .i_ch1_mod, .o_ch1_mod, .o_ch1_phase_cfg, .o_ch2_input_cfg, .o_reg_rdata,
    .o_ch2_digital_volume);

/* File: host_port_model.sv */
`timescale 1ns/1ps
module host_port_model
    import adc_cfg_pkg::*;
(
    input  wire logic i_ref_clk,
    output reg_req_t  o_req
);
    initial o_req = '0;
    // One-cycle strobe, then released bus shows inverted address and data
    task automatic access(input logic w, input logic [7:0] a, d);
        @(posedge i_ref_clk);
        o_req <= '{w, !w, a, d};
        @(posedge i_ref_clk);
        o_req <= '{1'b0, 1'b0, ~a, ~d};
        #1;
    endtask
endmodule // host_port_model

/* File: adc_channel_config_regs_tb.sv */
`timescale 1ns/1ps
module adc_channel_config_regs_tb
    import adc_cfg_pkg::*;
;
    logic           i_ref_clk, i_rst_n, i_mod_clk_en, o_reg_hit, o_reg_rd_valid, o_ch2_mute;
    logic           o_ch2_config_conflict;
    logic [7:0]     o_reg_rdata, o_ch2_digital_volume;
    reg_req_t       i_reg_req;
    mod_pair_t      i_ch1_mod, o_ch1_mod;
    ch1_phase_cfg_t o_ch1_phase_cfg;
    ch2_input_cfg_t o_ch2_input_cfg;
    int             err_count = 0;
    int             num_checks = 0;
    adc_channel_config_regs dut (.i_ref_clk, .i_rst_n, .i_reg_req, .o_reg_hit, .o_reg_rdata,
        .o_reg_rd_valid, .i_mod_clk_en, .i_ch1_mod, .o_ch1_mod, .o_ch1_phase_cfg,
        .o_ch2_input_cfg, .o_ch2_digital_volume, .o_ch2_mute, .o_ch2_config_conflict);
    host_port_model host (.i_ref_clk, .o_req(i_reg_req));
    task automatic chk(input string n, input logic [7:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, exp);
        host.access(1'b0, a, 8'h00);
        chk("rd_valid", o_reg_rd_valid, 8'h01);
        chk("rdata", o_reg_rdata, exp);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_reset;
        rd_chk(CH1_PHASE_DELAY_CONFIG_OFS, CH1_PHASE_DELAY_CONFIG_RST);
        rd_chk(CH2_INPUT_CONFIG_OFS, CH2_INPUT_CONFIG_RST);
        rd_chk(CH2_VOLUME_CONFIG_OFS, VOLUME_0DB_CODE);
        $display("end reset values");
    endtask
    task automatic t_regs;
        logic [7:0] cv [7] = '{8'h0A, 8'h06, 8'h21, 8'h11, 8'h40, 8'h80, 8'hFF};
        logic [0:6] ce = 7'b0101001;
        host.access(1'b1, CH2_VOLUME_CONFIG_OFS, VOLUME_MUTE_CODE);
        chk("mute", o_ch2_mute, 8'h01);
        host.access(1'b1, 8'h56, 8'h55);
        rd_chk(8'h56, 8'h00);
        rd_chk(CH2_VOLUME_CONFIG_OFS, VOLUME_MUTE_CODE);
        host.access(1'b1, CH2_VOLUME_CONFIG_OFS, VOLUME_MAX_CODE);
        chk("mute", o_ch2_mute, 8'h00);
        for (int i = 0; i < 7; i++) begin
            host.access(1'b1, CH2_INPUT_CONFIG_OFS, cv[i]);
            chk("conflict", o_ch2_config_conflict, {7'h00, ce[i]});
            chk("source", o_ch2_input_cfg.ch2_input_source, cv[i][7:6]);
            rd_chk(CH2_INPUT_CONFIG_OFS, cv[i]);
        end
        $display("end register access");
    endtask
    task automatic t_delay(input logic [5:0] d, input logic [1:0] p);
        int ka;
        int kd;
        ka = p[1] ? 0 : int'(d);
        kd = p[0] ? 0 : int'(d);
        host.access(1'b1, CH1_PHASE_DELAY_CONFIG_OFS, {d, p});
        for (int k = -64; k <= 64; k++) begin
            @(posedge i_ref_clk);
            i_mod_clk_en <= 1'b1;
            i_ch1_mod <= (k == 0) ? 2'b11 : 2'b00;
            #1;
            if (k >= 1)
                chk("stream", o_ch1_mod, {6'h00, k - 1 == ka, k - 1 == kd});
        end
        @(posedge i_ref_clk);
        i_mod_clk_en <= 1'b0;
        rd_chk(CH1_PHASE_DELAY_CONFIG_OFS, {d, p});
        $display("end delay %0d path %0d", d, p);
    endtask
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        err_count++;
        summarize;
    end
    initial begin
        i_rst_n = 1'b0;
        i_mod_clk_en = 1'b0;
        i_ch1_mod = '0;
        repeat (3) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset;
        t_regs;
        t_delay(6'd0, 2'd0);
        t_delay(6'd63, 2'd0);
        t_delay(6'd1, 2'd0);
        t_delay(6'd5, 2'd1);
        t_delay(6'd5, 2'd2);
        t_delay(6'd5, 2'd3);
        summarize;
    end
endmodule // adc_channel_config_regs_tb
